// ---- logic/mae_exception_entry.sv ----
// Exception entry for translation and address faults, with AHB-Lite registers
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Data multi-hit records code 140 and branches to the reset vector.
// RULE2 - Multi-hit clears vector base, sets priv/bank/block, clears FD, mask ones.
// RULE3 - Multi-hit also pulses module initialisation like a manual reset.
// RULE4 - Every fault latches address and page number; address space id kept.
// RULE5 - Data miss records 040 read or 060 write, branches base plus 400.
// RULE6 - Non-reset faults save pc, status and register fifteen.
// RULE7 - Non-reset faults set priv, bank, block bits; vector base unchanged.
// RULE8 - Fetch miss records 040 and branches to base plus 400.
// RULE9 - Store to clean page records 080, branches base plus 100.
// RULE10 - Data accesses checked against two-bit protection field table.
// RULE11 - Data protection violation records 0A0 read or 0C0 write, base plus 100.
// RULE12 - Fetch protection: privileged always, user only when field is one.
// RULE13 - Fetch protection violation records 0A0, branches base plus 100.
// RULE14 - Misaligned word, longword or quadword data access is address error.
// RULE15 - User data access in upper half of space is address error.
// RULE16 - Data address error records 0E0 read or 100 write, base plus 100.
// RULE17 - Odd or user upper-half fetch records 0E0, base plus 100.
// RULE18 - Any fault with block bit set does manual-reset style entry instead.
// RULE19 - Event code zero-extended; all captures in the redirect cycle.
module mae_exception_entry
  import mae_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Pipeline and translation buffers
  input  wire mae_dacc_s   dacc,
  input  wire mae_ifch_s   ifch,
  input  wire logic [31:0] general_register_fifteen,
  // Redirect and core state
  output logic             redirect,
  output logic [31:0]      redirect_pc,
  output logic             module_init,
  output logic [31:0]      status_word,
  output logic [31:0]      vector_base_reg,
  output logic             irq
);

  mae_state_s st_r;
  mae_state_s st_nxt;

  // Fault decode signals
  logic              user_mode;
  logic              d_addr_err;
  logic              d_prot_err;
  logic              i_addr_err;
  logic              i_prot_err;
  logic [EV_COUNT-1:0] ev;
  logic              fault;
  logic              reset_like;
  logic [11:0]       code;
  logic [31:0]       fault_addr;
  logic [31:0]       fault_pc;
  logic [31:0]       vec_ofs;
  logic [31:0]       rd_val;

  // Protection and alignment checks of both streams
  always_comb begin
    user_mode = ~st_r.status_word[SW_PRIV_POS];
    d_addr_err = 1'b0;
    unique case (dacc.size)
      SZ_WORD: d_addr_err = dacc.addr[0];                 // RULE14
      SZ_LONG: d_addr_err = |dacc.addr[1:0];              // RULE14
      SZ_QUAD: d_addr_err = |dacc.addr[2:0];              // RULE14
      default: d_addr_err = 1'b0;
    endcase
    if (user_mode && dacc.addr >= UPPER_HALF) begin
      d_addr_err = 1'b1;                                  // RULE15
    end
    // Upper bit grants user access, lower bit grants writes
    d_prot_err = (user_mode && !dacc.prot[1]) ||
                 (dacc.write && !dacc.prot[0]);           // RULE10
    i_addr_err = ifch.addr[0] ||
                 (user_mode && ifch.addr >= UPPER_HALF);  // RULE17
    i_prot_err = user_mode && !ifch.prot;                 // RULE12
  end

  // Events; alignment checks mask lookup results since the lookup is moot
  always_comb begin
    ev = '0;
    if (dacc.valid) begin
      ev[EV_DADDR]  = d_addr_err;
      ev[EV_DMULTI] = !d_addr_err && dacc.multi;
      ev[EV_DMISS]  = !d_addr_err && !dacc.multi && dacc.miss;
      ev[EV_DPROT]  = !d_addr_err && !dacc.multi && !dacc.miss &&
                      d_prot_err;
      ev[EV_IWRITE] = !d_addr_err && !dacc.multi && !dacc.miss &&
                      !d_prot_err && dacc.write && !dacc.dirty; // RULE9
    end
    if (ifch.valid) begin
      ev[EV_IADDR] = i_addr_err;
      ev[EV_IMISS] = !i_addr_err && ifch.miss;
      ev[EV_IPROT] = !i_addr_err && !ifch.miss && i_prot_err;
    end
  end

  // Pick one fault; the data access is older, so it goes first
  always_comb begin
    fault      = 1'b1;
    reset_like = 1'b0;
    fault_addr = dacc.addr;
    fault_pc   = dacc.pc;
    vec_ofs    = OFS_GEN_VEC;
    code       = EC_MANUAL_RESET;
    if (ev[EV_DADDR]) begin
      code = dacc.write ? EC_ADDR_WRITE : EC_ADDR_READ;   // RULE16
    end else if (ev[EV_DMULTI]) begin
      code       = EC_MULTI_HIT;                          // RULE1
      reset_like = 1'b1;
    end else if (ev[EV_DMISS]) begin
      code    = dacc.write ? EC_MISS_WRITE : EC_MISS_READ; // RULE5
      vec_ofs = OFS_MISS_VEC;                             // RULE5
    end else if (ev[EV_DPROT]) begin
      code = dacc.write ? EC_PROT_WRITE : EC_PROT_READ;   // RULE11
    end else if (ev[EV_IWRITE]) begin
      code = EC_INIT_WRITE;                               // RULE9
    end else begin
      fault_addr = ifch.addr;
      fault_pc   = ifch.addr;
      if (ev[EV_IADDR]) begin
        code = EC_ADDR_READ;                              // RULE17
      end else if (ev[EV_IMISS]) begin
        code    = EC_MISS_READ;                           // RULE8
        vec_ofs = OFS_MISS_VEC;                           // RULE8
      end else if (ev[EV_IPROT]) begin
        code = EC_PROT_READ;                              // RULE13
      end else begin
        fault = 1'b0;
      end
    end
    // A fault while blocked cannot nest, so the core restarts instead
    if (fault && st_r.status_word[SW_BLOCK_POS] && !reset_like) begin
      reset_like = 1'b1;                                  // RULE18
      code       = EC_MANUAL_RESET;                       // RULE18
    end
  end

  // Next state: bus write, fault entry, interrupt flags, bus capture
  always_comb begin
    st_nxt = st_r;
    rd_val = 32'h0000_0000;
    st_nxt.redirect    = 1'b0;
    st_nxt.module_init = 1'b0;
    if (ce) begin
      // Data phase of a write commits here
      if (st_r.dph_write) begin
        unique case (st_r.dph_addr)
          OFS_PAGE_HIGH:
            st_nxt.page_entry_high_reg = hwdata & PEH_WRITABLE;
          OFS_VEC_BASE:
            st_nxt.vector_base_reg = hwdata;
          OFS_STATUS:
            st_nxt.status_word = hwdata & SW_WRITABLE;
          OFS_INT_CLEAR:
            st_nxt.int_status = st_r.int_status & ~hwdata[EV_COUNT-1:0];
          OFS_INT_ENABLE:
            st_nxt.int_enable = hwdata[EV_COUNT-1:0];
          default: ;
        endcase
      end
      // Fault entry wins over a register write in the same cycle, except a vector base write during a non-reset fault
      if (fault) begin
        st_nxt.fault_address_reg = fault_addr;            // RULE4
        st_nxt.page_entry_high_reg[31:PEH_VPN_LSB] =
          fault_addr[31:PEH_VPN_LSB];                     // RULE4
        st_nxt.exception_event_reg = {20'h00000, code};   // RULE19
        st_nxt.redirect = 1'b1;                           // RULE19
        if (reset_like) begin
          st_nxt.vector_base_reg = VBR_RESET_VAL;         // RULE2
          st_nxt.status_word     = SW_RESET_VAL;          // RULE2
          st_nxt.redirect_pc     = RESET_VECTOR;          // RULE1
          st_nxt.module_init     = 1'b1;                  // RULE3
        end else begin
          st_nxt.saved_program_counter = fault_pc;        // RULE6
          st_nxt.saved_status_word     = st_r.status_word; // RULE6
          st_nxt.saved_general_reg = general_register_fifteen; // RULE6
          st_nxt.status_word = st_r.status_word | SW_ENTRY_SET; // RULE7
          st_nxt.redirect_pc = st_nxt.vector_base_reg + vec_ofs;
        end
      end
      // Sticky events; a new event beats a clear in the same cycle
      for (int i = 0; i < EV_COUNT; i++) begin
        if (ev[i]) begin
          st_nxt.int_status[i] = 1'b1;
        end
      end
      // Address phase; read data taken from the updated state
      st_nxt.dph_write = 1'b0;
      if (hsel && hready && htrans[1]) begin
        st_nxt.dph_write = hwrite;
        st_nxt.dph_addr  = {haddr[7:2], 2'b00};
        if (haddr[31:8] == 24'h000000) begin
          unique case ({haddr[7:2], 2'b00})
            OFS_FAULT_ADDR: rd_val = st_nxt.fault_address_reg;
            OFS_PAGE_HIGH:  rd_val = st_nxt.page_entry_high_reg;
            OFS_EVENT:      rd_val = st_nxt.exception_event_reg;
            OFS_VEC_BASE:   rd_val = st_nxt.vector_base_reg;
            OFS_STATUS:     rd_val = st_nxt.status_word;
            OFS_SAVED_PC:   rd_val = st_nxt.saved_program_counter;
            OFS_SAVED_SW:   rd_val = st_nxt.saved_status_word;
            OFS_SAVED_GR:   rd_val = st_nxt.saved_general_reg;
            OFS_INT_STATUS: rd_val = {24'h000000, st_nxt.int_status};
            OFS_INT_ENABLE: rd_val = {24'h000000, st_nxt.int_enable};
            default:        rd_val = 32'h0000_0000;
          endcase
        end else begin
          st_nxt.dph_addr = 8'hFC;                        // Unmapped, ignored
        end
        st_nxt.hrdata = hwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // Single register stage for the whole unit
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r                     <= '0;
      st_r.status_word         <= SW_RESET_VAL;
      st_r.vector_base_reg     <= VBR_RESET_VAL;
      st_r.exception_event_reg <= EVT_RESET_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs; bus stalls while the clock enable freezes the state
  assign hreadyout       = ce;
  assign hresp           = 1'b0;
  assign hrdata          = st_r.hrdata;
  assign redirect        = st_r.redirect;
  assign redirect_pc     = st_r.redirect_pc;
  assign module_init     = st_r.module_init;
  assign status_word     = st_r.status_word;
  assign vector_base_reg = st_r.vector_base_reg;
  assign irq = |(st_r.int_status & st_r.int_enable);

endmodule

// ---- logic/mae_pkg.sv ----
// Constants, field layouts and carrier types of the address exception unit
package mae_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_FAULT_ADDR  = 8'h00;
  localparam logic [7:0] OFS_PAGE_HIGH   = 8'h04;
  localparam logic [7:0] OFS_EVENT       = 8'h08;
  localparam logic [7:0] OFS_VEC_BASE    = 8'h0C;
  localparam logic [7:0] OFS_STATUS      = 8'h10;
  localparam logic [7:0] OFS_SAVED_PC    = 8'h14;
  localparam logic [7:0] OFS_SAVED_SW    = 8'h18;
  localparam logic [7:0] OFS_SAVED_GR    = 8'h1C;
  localparam logic [7:0] OFS_INT_STATUS  = 8'h20;
  localparam logic [7:0] OFS_INT_CLEAR   = 8'h24;
  localparam logic [7:0] OFS_INT_ENABLE  = 8'h28;

  // Status word field positions
  localparam int SW_PRIV_POS  = 30;
  localparam int SW_BANK_POS  = 29;
  localparam int SW_BLOCK_POS = 28;
  localparam int SW_FD_POS    = 15;
  localparam int SW_MASK_LSB  = 4;
  localparam int SW_MASK_MSB  = 7;
  localparam logic [31:0] SW_WRITABLE = 32'h7000_80F0;
  localparam logic [31:0] SW_ENTRY_SET = 32'h7000_0000;
  localparam logic [31:0] SW_RESET_VAL = 32'h7000_00F0;

  // Page entry high layout
  localparam int PEH_VPN_LSB  = 10;
  localparam int PEH_ADDRESS_SPACE_ID_MSB = 7;
  localparam logic [31:0] PEH_WRITABLE = 32'hFFFF_FCFF;

  // Reset values
  localparam logic [31:0] VBR_RESET_VAL = 32'h0000_0000;
  localparam logic [31:0] EVT_RESET_VAL = 32'h0000_0000;

  // Exception codes
  localparam logic [11:0] EC_MANUAL_RESET = 12'h020;
  localparam logic [11:0] EC_MULTI_HIT    = 12'h140;
  localparam logic [11:0] EC_MISS_READ    = 12'h040;
  localparam logic [11:0] EC_MISS_WRITE   = 12'h060;
  localparam logic [11:0] EC_INIT_WRITE   = 12'h080;
  localparam logic [11:0] EC_PROT_READ    = 12'h0A0;
  localparam logic [11:0] EC_PROT_WRITE   = 12'h0C0;
  localparam logic [11:0] EC_ADDR_READ    = 12'h0E0;
  localparam logic [11:0] EC_ADDR_WRITE   = 12'h100;

  // Branch targets
  localparam logic [31:0] RESET_VECTOR = 32'hA000_0000;
  localparam logic [31:0] OFS_MISS_VEC = 32'h0000_0400;
  localparam logic [31:0] OFS_GEN_VEC  = 32'h0000_0100;
  localparam logic [31:0] UPPER_HALF   = 32'h8000_0000;

  // Event bit positions in the interrupt status register
  localparam int EV_DMULTI = 0;
  localparam int EV_DMISS  = 1;
  localparam int EV_IMISS  = 2;
  localparam int EV_IWRITE = 3;
  localparam int EV_DPROT  = 4;
  localparam int EV_IPROT  = 5;
  localparam int EV_DADDR  = 6;
  localparam int EV_IADDR  = 7;
  localparam int EV_COUNT  = 8;

  // Data access sizes
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2,
    SZ_QUAD = 2'h3
  } mae_size_e;

  // Data access with its unified translation result
  typedef struct packed {
    logic        valid;
    logic        write;
    mae_size_e   size;
    logic [31:0] addr;
    logic [31:0] pc;
    logic        miss;
    logic        multi;
    logic [1:0]  prot;
    logic        dirty;
  } mae_dacc_s;

  // Instruction fetch with its instruction translation result
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        miss;
    logic        prot;
  } mae_ifch_s;

  // All state of the unit
  typedef struct packed {
    logic [31:0]         fault_address_reg;
    logic [31:0]         page_entry_high_reg;
    logic [31:0]         exception_event_reg;
    logic [31:0]         vector_base_reg;
    logic [31:0]         status_word;
    logic [31:0]         saved_program_counter;
    logic [31:0]         saved_status_word;
    logic [31:0]         saved_general_reg;
    logic [EV_COUNT-1:0] int_status;
    logic [EV_COUNT-1:0] int_enable;
    logic                dph_write;
    logic [7:0]          dph_addr;
    logic [31:0]         hrdata;
    logic                redirect;
    logic [31:0]         redirect_pc;
    logic                module_init;
  } mae_state_s;

endpackage

// ---- testbench/mae_exception_entry_checker.sv ----
// Concurrent checks on the exception entry outputs
`timescale 1ns/1ps
module mae_exception_entry_checker
  import mae_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        ce,
  input wire mae_dacc_s   dacc,
  input wire mae_ifch_s   ifch,
  input wire logic        redirect,
  input wire logic [31:0] redirect_pc,
  input wire logic        module_init,
  input wire logic [31:0] status_word,
  input wire logic [31:0] vector_base_reg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Entry shapes seen the cycle after the fault edge
  sequence s_gen_entry;
    redirect && redirect_pc == vector_base_reg + OFS_GEN_VEC;
  endsequence
  sequence s_miss_entry;
    redirect && redirect_pc == vector_base_reg + OFS_MISS_VEC;
  endsequence
  sequence s_reset_entry;
    redirect && module_init && redirect_pc == RESET_VECTOR;
  endsequence
  // Byte access in the lower half can never be an address error
  logic d_clean;
  logic blk;
  assign d_clean = ce && dacc.valid && dacc.size == SZ_BYTE && !dacc.addr[31];
  assign blk = status_word[SW_BLOCK_POS];
  chk_init_redirect: assert property (
    module_init |-> s_reset_entry) else $error("init without reset entry");
  chk_init_state: assert property (
    module_init |-> vector_base_reg == VBR_RESET_VAL
      && status_word == SW_RESET_VAL) else $error("init state wrong");
  chk_entry_bits: assert property (
    redirect |-> status_word[30:28] == 3'h7) else $error("entry bits unset");
  chk_data_miss: assert property (
    d_clean && dacc.miss && !dacc.multi && !blk |=> s_miss_entry)
    else $error("data miss target wrong");
  chk_fetch_miss: assert property (
    ce && ifch.valid && ifch.miss && !ifch.addr[0] && !ifch.addr[31]
      && !dacc.valid && !blk |=> s_miss_entry) else $error("fetch miss wrong");
  chk_multi_hit: assert property (
    d_clean && dacc.multi |=> s_reset_entry) else $error("multi-hit wrong");
  chk_odd_word: assert property (
    ce && dacc.valid && dacc.size == SZ_WORD && dacc.addr[0] && !blk
      |=> s_gen_entry) else $error("odd word not trapped");
  chk_odd_fetch: assert property (
    ce && ifch.valid && ifch.addr[0] && !dacc.valid && !blk
      |=> s_gen_entry) else $error("odd fetch not trapped");
  chk_block_entry: assert property (
    d_clean && dacc.miss && blk |=> s_reset_entry)
    else $error("blocked fault not reset-like");
endmodule

bind mae_exception_entry mae_exception_entry_checker u_chk (
  .mclk(mclk), .reset(reset), .ce(ce), .dacc(dacc), .ifch(ifch),
  .redirect(redirect), .redirect_pc(redirect_pc),
  .module_init(module_init), .status_word(status_word),
  .vector_base_reg(vector_base_reg)
);

// ---- testbench/mae_exception_entry_tb_top.sv ----
// Directed bench for the address exception entry unit
`timescale 1ns/1ps
module mae_exception_entry_tb_top import mae_pkg::*;;
  localparam logic [31:0] PRV = 32'h4000_0000;
  localparam logic [31:0] USR = 32'h0000_0000;
  localparam logic [31:0] VB  = 32'h1000_0000;
  localparam logic [31:0] PCV = 32'h0C00_1230;
  logic        mclk, reset, ce, hsel, hwrite, hreadyout, hresp;
  logic        redirect, module_init, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, redirect_pc, r15, rd;
  logic [31:0] status_word, vector_base_reg;
  mae_dacc_s   dacc, nda;
  mae_ifch_s   ifch, nf;
  int          err_count, checks;

  mae_pipe_model u_mae_pipe_model (.mclk(mclk), .dacc(dacc), .ifch(ifch),
    .general_register_fifteen(r15));
  mae_exception_entry u_mae_exception_entry (.mclk(mclk), .reset(reset),
    .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dacc(dacc),
    .ifch(ifch), .general_register_fifteen(r15), .redirect(redirect),
    .redirect_pc(redirect_pc), .module_init(module_init),
    .status_word(status_word), .vector_base_reg(vector_base_reg), .irq(irq));

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  task automatic summarize();
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bounded wait for hready; a hang ends the run
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      summarize();
    end
  endtask
  // Single word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    r = hrdata;
  endtask
  function automatic mae_dacc_s da(logic w, mae_size_e s, logic [31:0] a,
                                   logic m, logic mh, logic [1:0] p, logic d);
    da = '{1'b1, w, s, a, PCV, m, mh, p, d};
  endfunction
  function automatic mae_ifch_s fe(logic [31:0] a, logic m, logic p);
    fe = '{1'b1, a, m, p};
  endfunction
  // Arm status and base, present one access, check every capture
  task automatic run(input logic [31:0] sw, input mae_dacc_s d,
                     input mae_ifch_s f, input logic [11:0] code);
    logic [31:0] fa, tg;
    logic        rl;
    rl = sw[SW_BLOCK_POS] | (d.valid & d.multi);
    fa = d.valid ? d.addr : f.addr;
    tg = (code == EC_MISS_READ || code == EC_MISS_WRITE) ? OFS_MISS_VEC
                                                         : OFS_GEN_VEC;
    tg = rl ? RESET_VECTOR : VB + tg;
    xfer(1'b1, OFS_VEC_BASE, VB, rd);
    xfer(1'b1, OFS_STATUS, sw, rd);
    u_mae_pipe_model.present(d, f);
    #1;
    if (code == 12'h000) begin
      chk({31'h0, redirect}, 32'h0);
      return;
    end
    chk({30'h0, redirect, module_init}, {30'h0, 1'b1, rl});
    chk(redirect_pc, tg);
    chk(status_word, rl ? SW_RESET_VAL : sw | SW_ENTRY_SET);
    chk(vector_base_reg, rl ? VBR_RESET_VAL : VB);
    xfer(1'b0, OFS_EVENT, 32'h0, rd);
    chk(rd, {20'h0, code});
    xfer(1'b0, OFS_FAULT_ADDR, 32'h0, rd);
    chk(rd, fa);
    xfer(1'b0, OFS_PAGE_HIGH, 32'h0, rd);
    chk({rd[31:10], 10'h0}, {fa[31:10], 10'h0});
    if (rl) return;
    xfer(1'b0, OFS_SAVED_PC, 32'h0, rd);
    chk(rd, d.valid ? d.pc : f.addr);
    xfer(1'b0, OFS_SAVED_SW, 32'h0, rd);
    chk(rd, sw);
    xfer(1'b0, OFS_SAVED_GR, 32'h0, rd);
    chk(rd, ~d.pc);
  endtask

  // Main sequence: reset, bus, interrupt, then each fault kind
  initial begin
    reset = 1'b1; ce = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = '0; err_count = 0; checks = 0;
    nda = '0; nf = '0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    xfer(1'b0, 8'h30, 32'h0, rd);
    chk(rd, 32'h0);
    xfer(1'b1, OFS_INT_ENABLE, 32'h2, rd);
    run(PRV, da(0, SZ_BYTE, 32'h1234_5677, 1, 0, 3, 1), nf, EC_MISS_READ);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b0, OFS_INT_STATUS, 32'h0, rd);
    chk(rd, 32'h2);
    xfer(1'b1, OFS_INT_ENABLE, 32'h0, rd);
    #1 chk({31'h0, irq}, 32'h0);
    xfer(1'b1, OFS_INT_ENABLE, 32'h2, rd);
    #1 chk({31'h0, irq}, 32'h1);
    xfer(1'b1, OFS_INT_CLEAR, 32'h2, rd);
    #1 chk({31'h0, irq}, 32'h0);
    run(PRV, da(1, SZ_LONG, 32'h0ABC_D008, 1, 0, 3, 1), nf, EC_MISS_WRITE);
    run(PRV, nda, fe(32'h0040_0102, 1, 1), EC_MISS_READ);
    run(USR, da(1, SZ_WORD, 32'h0000_2002, 0, 0, 3, 0), nf, EC_INIT_WRITE);
    run(USR, da(0, SZ_BYTE, 32'h0000_3001, 0, 0, 0, 1), nf, EC_PROT_READ);
    run(USR, da(1, SZ_BYTE, 32'h0000_3003, 0, 0, 2, 1), nf, EC_PROT_WRITE);
    run(PRV, da(1, SZ_BYTE, 32'h0000_3005, 0, 0, 0, 1), nf, EC_PROT_WRITE);
    run(PRV, da(0, SZ_BYTE, 32'h0000_3007, 0, 0, 0, 1), nf, 12'h000);
    run(USR, nda, fe(32'h0000_4000, 0, 0), EC_PROT_READ);
    run(USR, nda, fe(32'h0000_4002, 0, 1), 12'h000);
    run(USR, da(0, SZ_WORD, 32'h0000_5001, 0, 0, 3, 1), nf, EC_ADDR_READ);
    run(PRV, da(1, SZ_LONG, 32'h0000_5006, 0, 0, 3, 1), nf, EC_ADDR_WRITE);
    run(PRV, da(1, SZ_QUAD, 32'h0000_500C, 0, 0, 3, 1), nf, EC_ADDR_WRITE);
    run(USR, da(0, SZ_LONG, 32'h8000_0010, 0, 0, 3, 1), nf, EC_ADDR_READ);
    run(PRV, da(0, SZ_LONG, 32'h8000_0010, 0, 0, 3, 1), nf, 12'h000);
    run(PRV, nda, fe(32'h0000_6001, 0, 1), EC_ADDR_READ);
    run(USR, nda, fe(32'hC000_0000, 0, 1), EC_ADDR_READ);
    run(32'h5000_0000, da(0, SZ_BYTE, 32'h7004, 1, 0, 3, 1), nf, EC_MANUAL_RESET);
    run(USR, da(0, SZ_BYTE, 32'h0000_8008, 0, 1, 3, 1), nf, EC_MULTI_HIT);
    summarize();
  end
endmodule

// ---- testbench/mae_pipe_model.sv ----
// Pipeline and translation buffer stand-in that presents one access
`timescale 1ns/1ps
module mae_pipe_model
  import mae_pkg::*;
(
  input  wire logic  mclk,
  output mae_dacc_s  dacc,
  output mae_ifch_s  ifch,
  output logic [31:0] general_register_fifteen
);
  initial begin
    dacc = '0;
    ifch = '0;
    general_register_fifteen = 32'hFFFF_FFFF;
  end
  // One cycle of access, then released lines show inverted junk
  task automatic present(input mae_dacc_s d, input mae_ifch_s f);
    mae_dacc_s jd;
    mae_ifch_s jf;
    jd = ~d;
    jd.valid = 1'b0; // Stale fields must never count
    jf = ~f;
    jf.valid = 1'b0;
    @(posedge mclk);
    dacc <= d;
    ifch <= f;
    general_register_fifteen <= ~d.pc;
    @(posedge mclk);
    dacc <= jd;
    ifch <= jf;
  endtask
endmodule
